/* rtl/icvt_pkg.sv */
// Purpose: Shared constants for the interrupt control and vector table block
// Assumes: APB word registers, 8 request sources, 40 MHz pclk
// Notes: Offsets are byte addresses on the APB side
package icvt_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int ICVT_NSRC = 8;
  localparam int ICVT_IDX_W = 3;
  localparam int ICVT_SIC_W = 9;
  localparam int ICVT_PRIO_W = 7;
  localparam int ICVT_TRAP_W = 4;
  localparam int ICVT_CC1_W = 7;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [11:0] ICVT_SIC_BASE = 12'h000;
  localparam logic [11:0] ICVT_BITMOD_BASE = 12'h040;
  localparam logic [11:0] ICVT_VECTOR_TABLE_SEGMENT_POINTER_OFF = 12'h080;
  localparam logic [11:0] ICVT_CC1_OFF = 12'h084;
  localparam logic [11:0] ICVT_TFR_OFF = 12'h088;
  localparam logic [11:0] ICVT_STATUS_OFF = 12'h08C;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int ICVT_GPX_BIT = 8;
  localparam int ICVT_IR_BIT = 7;
  localparam int ICVT_IE_BIT = 6;
  localparam int ICVT_SOURCE_PRIORITY_LEVEL_MSB = 5;
  localparam int ICVT_SOURCE_PRIORITY_LEVEL_LSB = 2;
  localparam int ICVT_GROUP_SUB_PRIORITY_MSB = 1;
  localparam int ICVT_MASK_LSB = 16;
  localparam int ICVT_VECTOR_SPACING_FIELD_MSB = 6;
  localparam int ICVT_VECTOR_SPACING_FIELD_LSB = 5;
  localparam logic [ICVT_SIC_W-1:0] ICVT_SIC_RESET = 9'h000;
  localparam logic [ICVT_CC1_W-1:0] ICVT_CC1_RESET = 7'h00;
  localparam logic [ICVT_TRAP_W-1:0] ICVT_TFR_RESET = 4'h0;

  // ****************************************
  // Vector table
  // ****************************************
  localparam logic [7:0] ICVT_SEG_INTERNAL = 8'hC0;
  localparam logic [7:0] ICVT_SEG_BOOT = 8'hBF;
  localparam logic [7:0] ICVT_SEG_EXTERNAL = 8'h00;
  localparam logic [7:0] ICVT_SRC_TRAP_BASE = 8'h10;
  localparam logic [7:0] ICVT_CLASS_B_TRAP = 8'h0A;
  localparam logic [4:0] ICVT_VEC_SHIFT_BASE = 5'h02;
  localparam logic [1:0] ICVT_STRAP_SETTLE = 2'h2;

  typedef enum logic [1:0] {
    ICVT_BOOT_INTERNAL = 2'b00,
    ICVT_BOOT_BOOTMEM = 2'b01,
    ICVT_BOOT_EXTERNAL = 2'b10,
    ICVT_BOOT_SYSTEM = 2'b11
  } icvt_boot_t;

  typedef enum logic [1:0] {
    ICVT_ARB_IDLE = 2'b00,
    ICVT_ARB_RUN = 2'b01,
    ICVT_ARB_OFFER = 2'b10
  } icvt_arb_state_t;

endpackage : icvt_pkg

/* rtl/icvt_arb_if.sv */
// Purpose: Carrier between source registers and the arbiter
// Assumes: Single pclk domain
// Notes: ctrl side owns the requests, arb side owns the winner
interface icvt_arb_if;
  import icvt_pkg::*;
  logic [ICVT_NSRC-1:0] active;
  logic [ICVT_NSRC-1:0][ICVT_PRIO_W-1:0] prio;
  logic rearm;
  logic win_valid;
  logic [ICVT_IDX_W-1:0] win_idx;
  logic [3:0] win_source_priority_level;
  logic busy;
  modport ctrl (output active, prio, rearm, input win_valid, win_idx, win_source_priority_level, busy);
  modport arb (input active, prio, rearm, output win_valid, win_idx, win_source_priority_level, busy);
endinterface : icvt_arb_if

/* rtl/icvt_vecgen.sv */
// Purpose: Vector address from segment, spacing and trap number
// Assumes: Byte addresses, word = 2 bytes
// Notes: Purely combinational
module icvt_vecgen
  import icvt_pkg::*;
(
  input wire logic [7:0] seg,
  input wire logic [1:0] spacing,
  input wire logic [7:0] trap_num,
  output logic [23:0] addr
);

  logic [4:0] shift;

  // ****************************************
  // Address forming
  // ****************************************
  always_comb begin
    shift = ICVT_VEC_SHIFT_BASE + {3'h0, spacing};
    addr = {seg, 16'({8'h00, trap_num} << shift)};
  end

endmodule : icvt_vecgen

/* rtl/icvt_arbiter.sv */
// Purpose: Picks the highest enabled request by level then group
// Assumes: Requests and priorities from the same clock
// Notes: Sleeps in idle while nothing is active
module icvt_arbiter
  import icvt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  icvt_arb_if.arb arb
);

  icvt_arb_state_t state_reg, state_next;
  logic [ICVT_NSRC-1:0] snap_reg, snap_next;
  logic win_valid_reg, win_valid_next;
  logic [ICVT_IDX_W-1:0] win_idx_reg, win_idx_next;
  logic [3:0] win_source_priority_level_reg, win_source_priority_level_next;
  logic best_found;
  logic [ICVT_PRIO_W-1:0] best_prio;
  logic [ICVT_IDX_W-1:0] best_idx;

  // ****************************************
  // Search and sequencing
  // ****************************************
  always_comb begin
    best_found = 1'b0;
    best_prio = '0;
    best_idx = '0;
    for (int i = 0; i < ICVT_NSRC; i++) begin
      if (arb.active[i] && (!best_found || arb.prio[i] > best_prio)) begin
        best_found = 1'b1;
        best_prio = arb.prio[i];
        best_idx = ICVT_IDX_W'(i);
      end
    end
    state_next = state_reg;
    snap_next = snap_reg;
    win_valid_next = win_valid_reg;
    win_idx_next = win_idx_reg;
    win_source_priority_level_next = win_source_priority_level_reg;
    case (state_reg)
      ICVT_ARB_IDLE: begin
        win_valid_next = 1'b0;
        if (|arb.active) begin
          state_next = ICVT_ARB_RUN;
        end
      end
      ICVT_ARB_RUN: begin
        snap_next = arb.active;
        win_valid_next = best_found;
        win_idx_next = best_idx;
        win_source_priority_level_next = best_prio[ICVT_PRIO_W-1:3];
        state_next = best_found ? ICVT_ARB_OFFER : ICVT_ARB_IDLE;
      end
      ICVT_ARB_OFFER: begin
        if (arb.rearm || arb.active != snap_reg) begin
          win_valid_next = 1'b0;
          state_next = (|arb.active) ? ICVT_ARB_RUN : ICVT_ARB_IDLE;
        end
      end
      default: begin
        win_valid_next = 1'b0;
        state_next = ICVT_ARB_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ICVT_ARB_IDLE;
      snap_reg <= '0;
      win_valid_reg <= 1'b0;
      win_idx_reg <= '0;
      win_source_priority_level_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      snap_reg <= snap_next;
      win_valid_reg <= win_valid_next;
      win_idx_reg <= win_idx_next;
      win_source_priority_level_reg <= win_source_priority_level_next;
    end
  end

  assign arb.win_valid = win_valid_reg;
  assign arb.win_idx = win_idx_reg;
  assign arb.win_source_priority_level = win_source_priority_level_reg;
  assign arb.busy = (state_reg != ICVT_ARB_IDLE);

endmodule : icvt_arbiter

/* rtl/icvt_top.sv */
// Purpose: Source control registers, vector table addressing, CPU offer
// Assumes: APB master on pclk; peripherals and CPU on pclk; strap pins async
// Notes: Registers reached over APB, one 32-bit word each
//
// Local design decisions: register access over APB and the register addresses.

module icvt_top
  import icvt_pkg::*;
#(
  parameter logic [7:0] VECTOR_TABLE_SEGMENT_POINTER_SYSTEM = 8'h00
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [ICVT_NSRC-1:0] src_event,
  input wire logic [ICVT_TRAP_W-1:0] trap_event,
  input wire logic [1:0] boot_select,
  input wire logic [3:0] cpu_level,
  input wire logic global_ie,
  input wire logic act_ack,
  output logic act_req,
  output logic [ICVT_IDX_W-1:0] act_src,
  output logic [3:0] act_level,
  output logic [23:0] act_vector,
  output logic trap_req,
  output logic [23:0] trap_vector
);

  icvt_arb_if arb_bus ();

  logic [ICVT_NSRC-1:0][ICVT_SIC_W-1:0] sic_reg, sic_next;
  logic [7:0] vector_table_segment_pointer_reg, vector_table_segment_pointer_next;
  logic [ICVT_CC1_W-1:0] cc1_reg, cc1_next;
  logic [ICVT_TRAP_W-1:0] tfr_reg, tfr_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [1:0] strap_s1_reg, strap_s2_reg;
  logic [1:0] strap_cnt_reg, strap_cnt_next;
  logic strap_done_reg, strap_done_next;
  logic act_req_reg, act_req_next;
  logic [ICVT_IDX_W-1:0] act_src_reg, act_src_next;
  logic [3:0] act_level_reg, act_level_next;
  logic [23:0] act_vector_reg, act_vector_next;
  logic trap_req_reg, trap_req_next;
  logic [23:0] trap_vector_reg, trap_vector_next;
  logic sel_sic, sel_bitmod, wr_fire, ack_fire;
  logic [ICVT_IDX_W-1:0] reg_idx;
  logic [23:0] src_vector, classb_vector;
  logic [7:0] strap_seg;

  // ****************************************
  // APB decode and read path
  // ****************************************
  always_comb begin
    sel_sic = (paddr[11:5] == ICVT_SIC_BASE[11:5]) && (paddr[1:0] == 2'b00);
    sel_bitmod = (paddr[11:5] == ICVT_BITMOD_BASE[11:5]) && (paddr[1:0] == 2'b00);
    reg_idx = paddr[4:2];
    wr_fire = psel && penable && pready_reg && pwrite;
    pready_next = psel && !penable;
    prdata_next = prdata_reg;
    pslverr_next = pslverr_reg;
    if (psel && !penable) begin
      pslverr_next = 1'b0;
      prdata_next = 32'h0000_0000;
      if (sel_sic || sel_bitmod) begin
        prdata_next = {23'h000000, sic_reg[reg_idx]};
      end else if (paddr == ICVT_VECTOR_TABLE_SEGMENT_POINTER_OFF) begin
        prdata_next = {24'h000000, vector_table_segment_pointer_reg};
      end else if (paddr == ICVT_CC1_OFF) begin
        prdata_next = {25'h0000000, cc1_reg};
      end else if (paddr == ICVT_TFR_OFF) begin
        prdata_next = {28'h0000000, tfr_reg};
      end else if (paddr == ICVT_STATUS_OFF) begin
        prdata_next = {22'h000000, arb_bus.busy, arb_bus.win_valid,
                       1'b0, arb_bus.win_idx, arb_bus.win_source_priority_level};
      end else begin
        pslverr_next = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // ****************************************
  // Source control registers
  // ****************************************
  assign ack_fire = act_ack && act_req_reg;

  for (genvar i = 0; i < ICVT_NSRC; i++) begin : g_src
    always_comb begin
      sic_next[i] = sic_reg[i];
      if (ack_fire && act_src_reg == ICVT_IDX_W'(i)) begin
        sic_next[i][ICVT_IR_BIT] = 1'b0;
      end
      if (wr_fire && !pslverr_reg && sel_sic && reg_idx == ICVT_IDX_W'(i)) begin
        sic_next[i] = pwdata[ICVT_SIC_W-1:0];
      end else if (wr_fire && !pslverr_reg && sel_bitmod && reg_idx == ICVT_IDX_W'(i)) begin
        sic_next[i] = (sic_reg[i] & ~pwdata[ICVT_MASK_LSB +: ICVT_SIC_W])
                    | (pwdata[ICVT_SIC_W-1:0] & pwdata[ICVT_MASK_LSB +: ICVT_SIC_W]);
      end
      if (src_event[i]) begin
        sic_next[i][ICVT_IR_BIT] = 1'b1;
      end
    end
    assign arb_bus.active[i] = sic_reg[i][ICVT_IR_BIT] && sic_reg[i][ICVT_IE_BIT];
    assign arb_bus.prio[i] = {sic_reg[i][ICVT_SOURCE_PRIORITY_LEVEL_MSB:ICVT_SOURCE_PRIORITY_LEVEL_LSB],
                              sic_reg[i][ICVT_GPX_BIT],
                              sic_reg[i][ICVT_GROUP_SUB_PRIORITY_MSB:0]};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sic_reg <= {ICVT_NSRC{ICVT_SIC_RESET}};
    end else begin
      sic_reg <= sic_next;
    end
  end

  // ****************************************
  // Boot strap capture and vector registers
  // ****************************************
  always_comb begin
    case (icvt_boot_t'(strap_s2_reg))
      ICVT_BOOT_INTERNAL: strap_seg = ICVT_SEG_INTERNAL;
      ICVT_BOOT_BOOTMEM: strap_seg = ICVT_SEG_BOOT;
      ICVT_BOOT_EXTERNAL: strap_seg = ICVT_SEG_EXTERNAL;
      ICVT_BOOT_SYSTEM: strap_seg = VECTOR_TABLE_SEGMENT_POINTER_SYSTEM;
      default: strap_seg = ICVT_SEG_EXTERNAL;
    endcase
    strap_cnt_next = strap_cnt_reg;
    strap_done_next = strap_done_reg;
    vector_table_segment_pointer_next = vector_table_segment_pointer_reg;
    cc1_next = cc1_reg;
    tfr_next = tfr_reg;
    if (!strap_done_reg) begin
      if (strap_cnt_reg == ICVT_STRAP_SETTLE) begin
        vector_table_segment_pointer_next = strap_seg;
        strap_done_next = 1'b1;
      end else begin
        strap_cnt_next = strap_cnt_reg + 2'h1;
      end
    end else if (wr_fire && paddr == ICVT_VECTOR_TABLE_SEGMENT_POINTER_OFF) begin
      vector_table_segment_pointer_next = pwdata[7:0];
    end
    if (wr_fire && paddr == ICVT_CC1_OFF) begin
      cc1_next = pwdata[ICVT_CC1_W-1:0];
    end
    if (wr_fire && paddr == ICVT_TFR_OFF) begin
      tfr_next = pwdata[ICVT_TRAP_W-1:0];
    end
    tfr_next = tfr_next | trap_event;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_s1_reg <= 2'b00;
      strap_s2_reg <= 2'b00;
      strap_cnt_reg <= 2'h0;
      strap_done_reg <= 1'b0;
      vector_table_segment_pointer_reg <= ICVT_SEG_EXTERNAL;
      cc1_reg <= ICVT_CC1_RESET;
      tfr_reg <= ICVT_TFR_RESET;
    end else begin
      strap_s1_reg <= boot_select;
      strap_s2_reg <= strap_s1_reg;
      strap_cnt_reg <= strap_cnt_next;
      strap_done_reg <= strap_done_next;
      vector_table_segment_pointer_reg <= vector_table_segment_pointer_next;
      cc1_reg <= cc1_next;
      tfr_reg <= tfr_next;
    end
  end

  // ****************************************
  // Arbiter and vector generators
  // ****************************************
  assign arb_bus.rearm = ack_fire;

  icvt_arbiter u_arbiter (
    .pclk(pclk),
    .presetn(presetn),
    .arb(arb_bus)
  );

  icvt_vecgen u_src_vec (
    .seg(vector_table_segment_pointer_reg),
    .spacing(cc1_reg[ICVT_VECTOR_SPACING_FIELD_MSB:ICVT_VECTOR_SPACING_FIELD_LSB]),
    .trap_num(ICVT_SRC_TRAP_BASE + {5'h00, arb_bus.win_idx}),
    .addr(src_vector)
  );

  icvt_vecgen u_classb_vec (
    .seg(vector_table_segment_pointer_reg),
    .spacing(cc1_reg[ICVT_VECTOR_SPACING_FIELD_MSB:ICVT_VECTOR_SPACING_FIELD_LSB]),
    .trap_num(ICVT_CLASS_B_TRAP),
    .addr(classb_vector)
  );

  // ****************************************
  // Action offer to the CPU
  // ****************************************
  always_comb begin
    act_req_next = arb_bus.win_valid && arb_bus.busy && !ack_fire
                && arb_bus.active[arb_bus.win_idx]
                && arb_bus.win_source_priority_level != 4'h0
                && arb_bus.win_source_priority_level > cpu_level && global_ie;
    act_src_next = arb_bus.win_idx;
    act_level_next = arb_bus.win_source_priority_level;
    act_vector_next = src_vector;
    trap_req_next = |tfr_reg;
    trap_vector_next = classb_vector;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_req_reg <= 1'b0;
      act_src_reg <= '0;
      act_level_reg <= 4'h0;
      act_vector_reg <= 24'h000000;
      trap_req_reg <= 1'b0;
      trap_vector_reg <= 24'h000000;
    end else begin
      act_req_reg <= act_req_next;
      act_src_reg <= act_src_next;
      act_level_reg <= act_level_next;
      act_vector_reg <= act_vector_next;
      trap_req_reg <= trap_req_next;
      trap_vector_reg <= trap_vector_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign act_req = act_req_reg;
  assign act_src = act_src_reg;
  assign act_level = act_level_reg;
  assign act_vector = act_vector_reg;
  assign trap_req = trap_req_reg;
  assign trap_vector = trap_vector_reg;

endmodule : icvt_top

/* tb/icvt_props.sv */
// Purpose: Port-level checks for the interrupt control block
// Assumes: One pclk domain, async active-low reset
// Notes: Attached by bind from the bench top
module icvt_props
  import icvt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [ICVT_NSRC-1:0] src_event,
  input wire logic [ICVT_TRAP_W-1:0] trap_event,
  input wire logic [1:0] boot_select,
  input wire logic [3:0] cpu_level,
  input wire logic global_ie,
  input wire logic act_ack,
  input wire logic act_req,
  input wire logic [ICVT_IDX_W-1:0] act_src,
  input wire logic [3:0] act_level,
  input wire logic [23:0] act_vector,
  input wire logic trap_req,
  input wire logic [23:0] trap_vector
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_apb_answer: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not a single cycle after setup");
  a_unmapped_err: assert property (psel && !penable && paddr >= 12'h090 |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_src_upper_zero: assert property (pready && !pwrite && paddr < 12'h080 |-> prdata[31:9] == 23'h0)
    else $error("source register upper bits not zero");
  a_seg_upper_zero: assert property (pready && !pwrite && paddr == 12'h080 |-> prdata[31:8] == 24'h0)
    else $error("segment register upper bits not zero");
  a_offer_cond: assert property (act_req |-> $past(global_ie) && act_level > $past(cpu_level))
    else $error("offer without enable or above cpu level");
  a_level_nonzero: assert property (act_req |-> act_level != 4'h0)
    else $error("level zero offered");
  a_ack_drops: assert property (act_req && act_ack |=> !act_req [*2])
    else $error("offer not withdrawn after accept");
  a_vector_form: assert property (act_req |-> act_vector[23:16] == trap_vector[23:16] &&
    32'(act_vector[15:0]) * 32'hA == 32'(trap_vector[15:0]) * (32'h10 + 32'(act_src)))
    else $error("source vector not scaled like trap vector");
  a_spacing_set: assert property (act_req |->
    trap_vector[15:0] inside {16'h0028, 16'h0050, 16'h00A0, 16'h0140})
    else $error("vector spacing outside legal set");
  a_trap_raise: assert property (|trap_event |-> ##[1:2] trap_req)
    else $error("trap request not raised");
endmodule : icvt_props

/* tb/icvt_cpu_model.sv */
// Purpose: CPU action unit stand-in that accepts offers
// Assumes: Same pclk as the block
// Notes: slow adds four wait cycles before accepting
module icvt_cpu_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic act_req,
  input wire logic slow,
  output logic act_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] wait_cnt;

  // One accept pulse per standing offer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_ack <= 1'b0;
      wait_cnt <= 3'h0;
    end else if (act_req && !act_ack && wait_cnt >= (slow ? 3'h4 : 3'h0)) begin
      act_ack <= 1'b1;
      wait_cnt <= 3'h0;
    end else begin
      act_ack <= 1'b0;
      wait_cnt <= (act_req && !act_ack) ? wait_cnt + 3'h1 : 3'h0;
    end
  end
endmodule : icvt_cpu_model

/* tb/tb_top.sv */
// Purpose: Self-checking bench for the interrupt control block
// Assumes: 40 MHz pclk, bench is APB master, CPU model accepts offers
// Notes: Several resets, one per boot strap value
module tb_top
  import icvt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] SYS_SEG = 8'h5A;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, global_ie, act_ack, act_req;
  logic trap_req, cpu_slow, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [7:0] src_event, seg;
  logic [3:0] trap_event, cpu_level, act_level;
  logic [1:0] boot_select, spacing;
  logic [2:0] act_src;
  logic [23:0] act_vector, trap_vector;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  `define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin mismatches++; \
    $display("Error at %0t: got %0h expected %0h", $time, got, exp); end end

  icvt_top #(.VECTOR_TABLE_SEGMENT_POINTER_SYSTEM(SYS_SEG)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_event(src_event), .trap_event(trap_event),
    .boot_select(boot_select), .cpu_level(cpu_level), .global_ie(global_ie),
    .act_ack(act_ack), .act_req(act_req), .act_src(act_src), .act_level(act_level),
    .act_vector(act_vector), .trap_req(trap_req), .trap_vector(trap_vector));
  icvt_cpu_model u_cpu (.pclk(pclk), .presetn(presetn), .act_req(act_req), .slow(cpu_slow),
    .act_ack(act_ack));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic do_reset(input logic [1:0] strap);
    presetn <= 1'b0;
    boot_select <= strap;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask : do_reset

  task automatic pulse_src(input logic [7:0] m);
    @(posedge pclk);
    src_event <= m;
    @(posedge pclk);
    src_event <= 8'h00;
  endtask : pulse_src

  task automatic expect_offer(input logic [2:0] src, input logic [3:0] lvl);
    int n;
    n = 0;
    while (act_req === 1'b1 && n < 12) begin
      @(posedge pclk);
      n++;
    end
    n = 0;
    while (act_req !== 1'b1 && n < 12) begin
      @(posedge pclk);
      n++;
    end
    `CHK(act_req, 1'b1)
    `CHK(act_src, src)
    `CHK(act_level, lvl)
    `CHK(act_vector, {seg, 16'({8'h00, ICVT_SRC_TRAP_BASE + 8'(src)}) << (spacing + 2)})
    n = 0;
    while (act_req === 1'b1 && n < 12) begin
      @(posedge pclk);
      n++;
    end
    `CHK(act_req, 1'b0)
  endtask : expect_offer

  task automatic no_offer();
    repeat (12) begin
      @(posedge pclk);
      `CHK(act_req, 1'b0)
    end
  endtask : no_offer

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_straps();
    logic [7:0] exp_seg [4];
    exp_seg = '{ICVT_SEG_INTERNAL, ICVT_SEG_BOOT, ICVT_SEG_EXTERNAL, SYS_SEG};
    for (int i = 0; i < 4; i++) begin
      do_reset(2'(i));
      apb(1'b0, ICVT_VECTOR_TABLE_SEGMENT_POINTER_OFF, 32'h0);
      `CHK(rdat, {24'h0, exp_seg[i]})
    end
    apb(1'b0, ICVT_CC1_OFF, 32'h0);
    `CHK(rdat, 32'h0)
    apb(1'b0, ICVT_SIC_BASE + 12'h01C, 32'h0);
    `CHK(rdat, 32'h0)
    apb(1'b0, ICVT_STATUS_OFF, 32'h0);
    `CHK(rdat[9], 1'b0)
  endtask : t_straps

  task automatic t_regs();
    apb(1'b1, ICVT_SIC_BASE + 12'h00C, 32'h0000_01FF);
    apb(1'b0, ICVT_SIC_BASE + 12'h00C, 32'h0);
    `CHK(rdat, 32'h0000_01FF)
    apb(1'b1, ICVT_SIC_BASE + 12'h00C, 32'h0);
    apb(1'b0, ICVT_SIC_BASE + 12'h00C, 32'h0);
    `CHK(rdat, 32'h0)
    apb(1'b1, ICVT_VECTOR_TABLE_SEGMENT_POINTER_OFF, {24'hFFFFFF, seg});
    apb(1'b0, ICVT_VECTOR_TABLE_SEGMENT_POINTER_OFF, 32'h0);
    `CHK(rdat, {24'h0, seg})
    apb(1'b1, 12'h090, 32'hFFFF_FFFF);
    `CHK(rerr, 1'b1)
    apb(1'b0, 12'h090, 32'h0);
    `CHK(rdat, 32'h0)
  endtask : t_regs

  task automatic t_bitmod();
    apb(1'b1, ICVT_BITMOD_BASE + 12'h00C, 32'h0040_0040);
    apb(1'b1, ICVT_BITMOD_BASE + 12'h00C, 32'h0004_0004);
    apb(1'b0, ICVT_SIC_BASE + 12'h00C, 32'h0);
    `CHK(rdat, 32'h0000_0044)
    @(posedge pclk);
    src_event[3] <= 1'b1;
    apb(1'b1, ICVT_SIC_BASE + 12'h00C, 32'h0);
    src_event[3] <= 1'b0;
    apb(1'b0, ICVT_SIC_BASE + 12'h00C, 32'h0);
    `CHK(rdat, 32'h0000_0080)
    apb(1'b1, ICVT_SIC_BASE + 12'h00C, 32'h0);
  endtask : t_bitmod

  task automatic t_vectors();
    cpu_level <= 4'h0;
    global_ie <= 1'b1;
    apb(1'b1, ICVT_SIC_BASE + 12'h008, 32'h0000_0054);
    for (int s = 0; s < 4; s++) begin
      spacing = 2'(s);
      cpu_slow <= spacing[0];
      apb(1'b1, ICVT_CC1_OFF, {25'h0, spacing, 5'h00});
      pulse_src(8'h04);
      expect_offer(3'h2, 4'h5);
      apb(1'b0, ICVT_SIC_BASE + 12'h008, 32'h0);
      `CHK(rdat, 32'h0000_0054)
    end
  endtask : t_vectors

  task automatic t_refuse();
    cpu_level <= 4'h3;
    apb(1'b1, ICVT_SIC_BASE, 32'h0000_00CC);
    no_offer();
    cpu_level <= 4'h2;
    expect_offer(3'h0, 4'h3);
    global_ie <= 1'b0;
    apb(1'b1, ICVT_SIC_BASE, 32'h0000_00D4);
    no_offer();
    global_ie <= 1'b1;
    expect_offer(3'h0, 4'h5);
    apb(1'b1, ICVT_SIC_BASE, 32'h0000_00C0);
    no_offer();
    apb(1'b1, ICVT_SIC_BASE, 32'h0);
  endtask : t_refuse

  task automatic t_prio();
    apb(1'b1, ICVT_SIC_BASE + 12'h004, 32'h0000_0064);
    apb(1'b1, ICVT_SIC_BASE + 12'h014, 32'h0000_015C);
    apb(1'b1, ICVT_SIC_BASE + 12'h018, 32'h0000_005D);
    pulse_src(8'h62);
    expect_offer(3'h1, 4'h9);
    expect_offer(3'h5, 4'h7);
    expect_offer(3'h6, 4'h7);
  endtask : t_prio

  task automatic t_trap();
    @(posedge pclk);
    trap_event <= 4'h2;
    @(posedge pclk);
    trap_event <= 4'h8;
    @(posedge pclk);
    trap_event <= 4'h0;
    repeat (3) @(posedge pclk);
    `CHK(trap_req, 1'b1)
    `CHK(trap_vector, {seg, 16'({8'h00, ICVT_CLASS_B_TRAP}) << (spacing + 2)})
    apb(1'b0, ICVT_TFR_OFF, 32'h0);
    `CHK(rdat, 32'h0000_000A)
    apb(1'b1, ICVT_TFR_OFF, 32'h0);
    repeat (3) @(posedge pclk);
    `CHK(trap_req, 1'b0)
  endtask : t_trap

  task automatic report_and_stop();
    if (mismatches == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    {psel, penable, pwrite, presetn, global_ie, cpu_slow} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    src_event = 8'h00;
    trap_event = 4'h0;
    boot_select = 2'h0;
    cpu_level = 4'hF;
    spacing = 2'h0;
    seg = 8'h34;
    t_straps();
    t_regs();
    t_bitmod();
    t_vectors();
    t_refuse();
    t_prio();
    t_trap();
    report_and_stop();
  end
endmodule : tb_top

bind icvt_top icvt_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .src_event(src_event), .trap_event(trap_event),
  .boot_select(boot_select), .cpu_level(cpu_level), .global_ie(global_ie),
  .act_ack(act_ack), .act_req(act_req), .act_src(act_src), .act_level(act_level),
  .act_vector(act_vector), .trap_req(trap_req), .trap_vector(trap_vector));
